// file: logic/adc_port_pkg.sv
// shared constants for the adc serial data and configuration port
package adc_port_pkg;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h058b;
  localparam logic [15:0] CODE_POS_MAX = 16'h7fff;
  localparam logic [15:0] CODE_NEG_MAX = 16'h8000;
  localparam int START_BIT = 15;
  localparam int CHAN_LSB = 12;
  localparam int GAIN_LSB = 9;
  localparam int MODE_BIT = 8;
  localparam int KEY_LSB = 1;
  localparam int RSVD_BIT = 0;
  localparam logic [1:0] KEY_WRITE = 2'h1;
  localparam logic [15:0] CONFIG_RO_MASK = 16'h0001;
  localparam int CLK_MHZ = 125;
  localparam int TIMEOUT_MS = 28;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int READY_LEAD_US = 8;
  localparam int READY_LEAD_CYCLES = READY_LEAD_US * CLK_MHZ;
  localparam int CONV_CYCLES_DEF = 20000;
  localparam int XFER_BITS = 32;
  localparam int WORD_BITS = 16;
endpackage

// file: logic/pin_sync.sv
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/10ps
`default_nettype none
module pin_sync
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic rst_val_i,
  // pin and clean level
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic lvl_d;

  always_comb
  begin
    lvl_d = lvl_q;
    if (s2_q == s3_q)
    begin
      lvl_d = s3_q;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    s1_q <= pin_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (sys_rst_i)
    begin
      lvl_q <= rst_val_i;
    end
    else
    begin
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;
endmodule
`default_nettype wire

// file: logic/adc_serial_port.sv
// serial data and configuration port of a 16-bit adc
`timescale 1ns/10ps
`default_nettype none
module adc_serial_port
  import adc_port_pkg::*;
#(
  parameter int CONV_CYCLES = adc_port_pkg::CONV_CYCLES_DEF,
  parameter int TIMEOUT = adc_port_pkg::TIMEOUT_CYCLES
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // serial pins
  input wire logic chip_select_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic serial_out_with_ready_flag_o,
  output logic serial_out_with_ready_flag_oe_o,
  // converter sample, already scaled; wider to show overrange
  input wire logic signed [17:0] sample_i,
  // configuration fields and conversion status to the analog front end
  output logic [2:0] input_channel_select_o,
  output logic [2:0] gain_range_select_o,
  output logic converting_o
);
  import adc_port_pkg::*;

  typedef enum logic [1:0]
  {
    CV_IDLE = 2'b00,
    CV_RUN = 2'b01
  } conv_state_t;

  logic cs_n;
  logic sclk;
  logic din;
  logic sclk_prev_q;
  logic rise;
  logic fall;

  pin_sync u_cs (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .rst_val_i(1'b1), .pin_i(chip_select_n_i), .level_o(cs_n));
  pin_sync u_sclk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .rst_val_i(1'b0), .pin_i(sclk_i), .level_o(sclk));
  pin_sync u_din (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .rst_val_i(1'b0), .pin_i(din_i), .level_o(din));

  assign rise = sclk & ~sclk_prev_q & ~cs_n;
  assign fall = ~sclk & sclk_prev_q & ~cs_n;

  // state
  conv_state_t cv_q, cv_d;
  logic [31:0] cv_cnt_q, cv_cnt_d;
  logic [15:0] result_q, result_d;
  logic [15:0] pending_q, pending_d;
  logic pend_q, pend_d;
  logic fresh_q, fresh_d;
  logic [15:0] config_q, config_d;
  logic [31:0] shreg_q, shreg_d;
  logic [15:0] inword_q, inword_d;
  logic [5:0] bitcnt_q, bitcnt_d;
  logic dout_q, dout_d;
  logic [31:0] idle_q, idle_d;
  logic start_req;
  logic [15:0] clipped;
  logic busy;

  // active transfer: selected and at least one clock edge seen
  assign busy = ~cs_n && (bitcnt_q != 6'h0 || sclk);

  always_comb
  begin
    if (sample_i > 18'sd32767)
    begin
      clipped = CODE_POS_MAX;
    end
    else if (sample_i < -18'sd32768)
    begin
      clipped = CODE_NEG_MAX;
    end
    else
    begin
      clipped = sample_i[15:0];
    end
  end

  // conversion sequencer
  always_comb
  begin
    cv_d = cv_q;
    cv_cnt_d = cv_cnt_q;
    pending_d = pending_q;
    case (cv_q)
      CV_IDLE:
      begin
        if (!config_q[MODE_BIT] || start_req)
        begin
          cv_d = CV_RUN;
          cv_cnt_d = 32'h0;
        end
      end
      CV_RUN:
      begin
        if (cv_cnt_q == 32'(CONV_CYCLES - 1))
        begin
          pending_d = clipped;
          cv_cnt_d = 32'h0;
          if (config_q[MODE_BIT])
          begin
            cv_d = CV_IDLE;
          end
        end
        else
        begin
          cv_cnt_d = cv_cnt_q + 32'h1;
        end
      end
      default:
      begin
        cv_d = CV_IDLE;
      end
    endcase
  end

  // result buffer, loaded only while no transfer runs
  always_comb
  begin
    result_d = result_q;
    fresh_d = fresh_q;
    pend_d = pend_q;
    if (pend_q && !busy)
    begin
      result_d = pending_q;
      fresh_d = 1'b1;
      pend_d = 1'b0;
    end
    else if (rise && bitcnt_q == 6'h0)
    begin
      fresh_d = 1'b0;
    end
    // a result finishing as the old one loads must stay pending
    if (cv_q == CV_RUN && cv_cnt_q == 32'(CONV_CYCLES - 1))
    begin
      pend_d = 1'b1;
    end
    // in continuous mode an unread result goes stale just before the next one lands
    if (!config_q[MODE_BIT] && cv_q == CV_RUN &&
        cv_cnt_q == 32'(CONV_CYCLES - 1 - READY_LEAD_CYCLES))
    begin
      fresh_d = 1'b0;
    end
  end

  // serial shifter and configuration write
  always_comb
  begin
    shreg_d = shreg_q;
    inword_d = inword_q;
    bitcnt_d = bitcnt_q;
    dout_d = dout_q;
    config_d = config_q;
    start_req = 1'b0;
    idle_d = sclk ? 32'h0 : idle_q + 32'h1;
    if (cs_n || (idle_q >= 32'(TIMEOUT) && !sclk))
    begin
      bitcnt_d = 6'h0;
      idle_d = 32'h0;
    end
    else
    begin
      if (rise)
      begin
        if (bitcnt_q == 6'h0)
        begin
          // snapshot so the word cannot change mid transfer
          shreg_d = {result_q[14:0], config_q & ~16'h8000, 1'b0};
          dout_d = result_q[15];
        end
        else
        begin
          dout_d = shreg_q[31];
          shreg_d = {shreg_q[30:0], 1'b0};
        end
      end
      if (fall)
      begin
        inword_d = {inword_q[14:0], din};
        bitcnt_d = bitcnt_q + 6'h1;
        if (bitcnt_q == 6'(WORD_BITS - 1) &&
            inword_d[KEY_LSB +: 2] == KEY_WRITE)
        begin
          config_d = (inword_d & ~CONFIG_RO_MASK & ~16'h8000)
                     | CONFIG_RO_MASK;
          start_req = inword_d[START_BIT] && cv_q == CV_IDLE
                      && inword_d[MODE_BIT];
        end
        // readback half carries the configuration as this word leaves it
        if (bitcnt_q == 6'(WORD_BITS - 1))
        begin
          shreg_d[31:16] = config_d & ~16'h8000;
        end
        if (bitcnt_q == 6'(XFER_BITS - 1))
        begin
          bitcnt_d = 6'(XFER_BITS); // 32; later falling edges keep counting until deselect or time-out
        end
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      sclk_prev_q <= 1'b0;
      cv_q <= CV_IDLE;
      cv_cnt_q <= 32'h0;
      result_q <= RESULT_RESET;
      pending_q <= RESULT_RESET;
      pend_q <= 1'b0;
      fresh_q <= 1'b0;
      config_q <= CONFIG_RESET;
      shreg_q <= 32'h0;
      inword_q <= 16'h0;
      bitcnt_q <= 6'h0;
      dout_q <= 1'b1;
      idle_q <= 32'h0;
    end
    else
    begin
      sclk_prev_q <= sclk;
      cv_q <= cv_d;
      cv_cnt_q <= cv_cnt_d;
      result_q <= result_d;
      pending_q <= pending_d;
      pend_q <= pend_d;
      fresh_q <= fresh_d;
      config_q <= config_d;
      shreg_q <= shreg_d;
      inword_q <= inword_d;
      bitcnt_q <= bitcnt_d;
      dout_q <= dout_d;
      idle_q <= idle_d;
    end
  end

  // before the first edge the line is the ready flag
  assign serial_out_with_ready_flag_o =
    (bitcnt_q == 6'h0 && !sclk_prev_q) ? ~fresh_q : dout_q;
  assign serial_out_with_ready_flag_oe_o = ~cs_n;
  assign input_channel_select_o = config_q[CHAN_LSB +: 3];
  assign gain_range_select_o = config_q[GAIN_LSB +: 3];
  assign converting_o = (cv_q == CV_RUN);
endmodule
`default_nettype wire

// file: verification/adc_port_monitor.sv
// pin-level checks on the adc serial port
`timescale 1ns/10ps
`default_nettype none
module adc_port_monitor
#(
  parameter int CONV_CYCLES = 200,
  parameter int TIMEOUT = 500
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // serial pins
  input wire logic chip_select_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic serial_out_with_ready_flag_o,
  input wire logic serial_out_with_ready_flag_oe_o,
  // front end
  input wire logic signed [17:0] sample_i,
  input wire logic [2:0] input_channel_select_o,
  input wire logic [2:0] gain_range_select_o,
  input wire logic converting_o
);
  wire cs = chip_select_n_i;
  wire sck = sclk_i;
  wire out = serial_out_with_ready_flag_o;
  wire oe = serial_out_with_ready_flag_oe_o;
  wire conv = converting_o;
  // data phase: a link clock pulse seen since selection
  logic seen_q;
  always_ff @(posedge core_clk_i)
  begin
    seen_q <= oe && (seen_q || sck);
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_oe_release: assert property (cs[*6] |-> !oe) else $error("oe on");
  a_oe_select: assert property (!cs[*6] |-> oe) else $error("oe off");
  a_oe_rise: assert property ($rose(oe) |-> !$past(cs, 2)) else $error("oe");
  a_oe_fall: assert property ($fell(oe) |-> $past(cs, 2)) else $error("oe");
  // data may only move after a rising link edge, never mid-bit
  a_out_on_edge: assert property ($changed(out) && oe && $past(oe, 2)
    && $past(seen_q)
    |-> $past(sck, 3)) else $error("data moved off edge");
  a_chan_in_frame: assert property ($changed(input_channel_select_o)
    |-> !$past(cs, 2)) else $error("channel moved outside frame");
  a_gain_in_frame: assert property ($changed(gain_range_select_o)
    |-> !$past(cs, 2)) else $error("gain moved outside frame");
  a_conv_length: assert property ($rose(conv) |-> conv[*8]) else $error("short");
endmodule
bind adc_serial_port adc_port_monitor
  #(.CONV_CYCLES(CONV_CYCLES), .TIMEOUT(TIMEOUT)) mon (.*);
`default_nettype wire

// file: verification/spi_host_model.sv
// host side of the link; clock idles low outside frames
`timescale 1ns/10ps
`default_nettype none
module spi_host_model
(
  // pins toward the port
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic line_i
);
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  // second half of a long frame holds din at w[0]
  task automatic xfer(input int n, input logic [15:0] w,
    output logic [31:0] r, output logic rdy);
    cs_n_o = 1'b0;
    #100;
    rdy = line_i;
    r = '0;
    for (int i = 0; i < n; i++)
    begin
      sclk_o = 1'b1;
      din_o = (i < 16) ? w[15 - i] : w[0];
      #62.5;
      r = {r[30:0], line_i};
      sclk_o = 1'b0;
      #62.5;
    end
    cs_n_o = 1'b1;
    #500;
  endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the adc serial port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import adc_port_pkg::*;
  localparam int CONV = 400;
  logic core_clk_i, sys_rst_i, chip_select_n_i, sclk_i, din_i;
  logic serial_out_with_ready_flag_o, serial_out_with_ready_flag_oe_o;
  logic signed [17:0] sample_i;
  logic [2:0] input_channel_select_o, gain_range_select_o;
  logic converting_o, line, rdy;
  logic [31:0] r;
  logic [1:0] bad [3] = '{2'h0, 2'h2, 2'h3};
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  // weak pull-up holds the line high while deselected
  assign line = serial_out_with_ready_flag_oe_o ?
    serial_out_with_ready_flag_o : 1'b1;
  adc_serial_port #(.CONV_CYCLES(CONV), .TIMEOUT(500)) uut (.*);
  spi_host_model host (.cs_n_o(chip_select_n_i), .sclk_o(sclk_i),
    .din_o(din_i), .line_i(line));
  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    sys_rst_i = 1'b1;
    sample_i = 18'sh0;
    // sync flops need four edges, longer than the usual two
    repeat (4) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    check("channel", 0, input_channel_select_o);
    check("gain", 3'h2, gain_range_select_o);
    check("converting", 0, converting_o);
    host.xfer(32, 16'hffff, r, rdy);
    check("ready", 1, rdy);
    check("frame", {RESULT_RESET, CONFIG_RESET}, r);
    for (int i = 0; i < 8; i++)
    begin
      host.xfer(32, {1'b0, i[2:0], i[2:0], 1'b1, 8'h8b}, r, rdy);
      check("readback", {1'b0, i[2:0], i[2:0], 9'h18b}, r);
      check("channel", i[2:0], input_channel_select_o);
      check("gain", i[2:0], gain_range_select_o);
    end
    sample_i = 18'sh1ffff;
    host.xfer(32, 16'hcb8b, r, rdy);
    check("readback", 32'h00004b8b, r);
    check("converting", 1, converting_o);
    for (int k = 0; k < 2 * CONV && converting_o !== 1'b0; k++)
      @(negedge core_clk_i);
    host.xfer(16, 16'h0000, r, rdy);
    check("ready", 0, rdy);
    check("result", CODE_POS_MAX, r[15:0]);
    host.xfer(16, 16'h0000, r, rdy);
    check("ready", 1, rdy);
    check("result", CODE_POS_MAX, r[15:0]);
    check("converting", 0, converting_o);
    foreach (bad[i])
    begin
      host.xfer(32, 16'h0489 | {13'h0, bad[i], 1'b0}, r, rdy);
      check("readback", 32'h7fff4b8b, r);
    end
    sample_i = 18'sh20000;
    host.xfer(32, 16'h048b, r, rdy);
    check("readback", 32'h7fff048b, r);
    repeat (3 * CONV) @(negedge core_clk_i);
    check("converting", 1, converting_o);
    host.xfer(16, 16'h0000, r, rdy);
    check("ready", 0, rdy);
    check("result", CODE_NEG_MAX, r[15:0]);
    sample_i = 18'sh00123;
    repeat (3 * CONV) @(negedge core_clk_i);
    host.xfer(16, 16'h0000, r, rdy);
    check("result", 16'h0123, r[15:0]);
    give_verdict();
  end
endmodule
`default_nettype wire
